// ===== verilog/rsp_regs.svh
// Field positions, reset values and release levels for the reset-source block
`ifndef RSP_REGS_SVH
`define RSP_REGS_SVH

`define RSP_WATCHDOG_BIT 0
`define RSP_UV_BIT 1
`define RSP_FLAGS_RST 8'h00
`define RSP_ZERO_RST 8'h00
`define RSP_ONES_RST 8'hFF
`define RSP_SB_MODE_RST 8'h01
`define RSP_SB_CTRL_RST 8'h16
`define RSP_BP_COUNT_RST 8'h07
`define RSP_BP_CTRL1_RST 8'h10
`define RSP_BP_CTRL3_RST 8'h1F
`define RSP_REL_LOW 1'b0
`define RSP_REL_HIGH 1'b1

`endif

// ===== verilog/rsp_pkg.sv
// Types shared by the reset-source block
package rsp_pkg;
	typedef enum logic [1:0] {
		RSP_PWR_HOLD = 2'b00,
		RSP_PWR_RUN = 2'b01
	} rsp_pwr_e;
	typedef logic [7:0] rsp_byte_t;
endpackage : rsp_pkg

// ===== verilog/rsp_reset_source.sv
// Reset-source flags, power-on-clear reset generation and peripheral reset values
`timescale 1ns/10ps
`default_nettype none
`include "rsp_regs.svh"

// Functional notes
// R1: Pin or power-on-clear reset zeroes cause flags
// R2: Reading cause flags returns them, then clears
// R3: Watchdog reset sets watchdog flag, holds other
// R4: Undervolt reset sets undervolt flag, holds other
// R5: Detector registers survive only undervolt reset
// R6: Software reads cause flags as whole bytes
// R7: All registers hold defined values in reset
// R8: Power-up reset; release level chosen by option
// R9: Supply below low level always forces reset
// R10: Serial B registers take documented reset values
// R11: Biphase registers take documented reset values
// R12: Request flags clear; masks, priorities set
// R13: Display, key and edge registers cleared
// R14: High mode waits for high release level
// R15: Reset held while any source active
module rsp_reset_source
	import rsp_pkg::*;
#(
	parameter int IRQ_BYTES = 4
) (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic reset_pin_n_i,
	input wire logic watchdog_reset_i,
	input wire logic undervolt_reset_i,
	input wire logic supply_above_low_i,
	input wire logic supply_above_high_i,
	input wire logic power_on_release_select_i,
	input wire logic flags_read_i,
	input wire logic detect_write_i,
	input wire logic [7:0] detect_wdata_i,
	output logic internal_reset_o,
	output logic [7:0] reset_cause_flags_o,
	output logic [7:0] undervolt_detect_control_o,
	output logic [7:0] undervolt_level_select_o,
	output logic [7:0] serial_b_mode_o,
	output logic [7:0] serial_b_control_o,
	output logic [7:0] serial_b_baud_divider_o,
	output logic [7:0] serial_b_rx_buffer_o,
	output logic [7:0] serial_b_tx_buffer_o,
	output logic [7:0] biphase_transmit_buffer_o,
	output logic [7:0] biphase_bit_count_o,
	output logic [7:0] biphase_control_first_o,
	output logic [7:0] biphase_control_third_o,
	output logic [7:0] biphase_state_o,
	output logic [7:0] display_mode_a_o,
	output logic [7:0] display_mode_b_o,
	output logic [7:0] display_clock_control_o,
	output logic [7:0] key_return_mode_o,
	output logic [7:0] rising_edge_enable_o,
	output logic [7:0] falling_edge_enable_o,
	output logic [8*IRQ_BYTES-1:0] irq_request_o,
	output logic [8*IRQ_BYTES-1:0] irq_mask_o,
	output logic [8*IRQ_BYTES-1:0] irq_priority_o
);

	rsp_pwr_e pwr_state;
	rsp_pwr_e next_pwr_state;
	logic pwr_reset;
	logic cold_reset;
	logic any_reset;
	logic next_internal_reset;
	rsp_byte_t flags;
	rsp_byte_t next_flags;
	rsp_byte_t det_ctrl;
	rsp_byte_t next_det_ctrl;
	rsp_byte_t det_level;
	rsp_byte_t next_det_level;
	rsp_byte_t next_serial_b_mode;
	rsp_byte_t next_serial_b_control;
	rsp_byte_t next_serial_b_baud_divider;
	rsp_byte_t next_serial_b_rx_buffer;
	rsp_byte_t next_serial_b_tx_buffer;
	rsp_byte_t next_biphase_transmit_buffer;
	rsp_byte_t next_biphase_bit_count;
	rsp_byte_t next_biphase_control_first;
	rsp_byte_t next_biphase_control_third;
	rsp_byte_t next_biphase_state;
	rsp_byte_t next_display_mode_a;
	rsp_byte_t next_display_mode_b;
	rsp_byte_t next_display_clock_control;
	rsp_byte_t next_key_return_mode;
	rsp_byte_t next_rising_edge_enable;
	rsp_byte_t next_falling_edge_enable;

	// Power-on-clear: hold until release level, re-enter below low level
	always_comb begin
		next_pwr_state = pwr_state;
		unique case (pwr_state)
			RSP_PWR_HOLD: begin
				if (power_on_release_select_i == `RSP_REL_HIGH) begin
					if (supply_above_high_i && supply_above_low_i) next_pwr_state = RSP_PWR_RUN; // R8 R14
				end else if (supply_above_low_i) begin
					next_pwr_state = RSP_PWR_RUN; // R8
				end
			end
			RSP_PWR_RUN: begin
				if (!supply_above_low_i) next_pwr_state = RSP_PWR_HOLD; // R9
			end
			default: next_pwr_state = RSP_PWR_HOLD;
		endcase
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pwr_state <= RSP_PWR_HOLD; // R8
		end else begin
			pwr_state <= next_pwr_state;
		end
	end

	assign pwr_reset = (pwr_state == RSP_PWR_HOLD) || !supply_above_low_i; // R9
	assign cold_reset = !reset_pin_n_i || pwr_reset;
	assign any_reset = cold_reset || watchdog_reset_i || undervolt_reset_i; // R15
	assign next_internal_reset = any_reset; // R15

	// Cause flags and detector settings
	always_comb begin
		next_flags = flags;
		next_det_ctrl = det_ctrl;
		next_det_level = det_level;
		if (flags_read_i) next_flags = `RSP_FLAGS_RST; // R2 R6
		if (detect_write_i && !any_reset) next_det_ctrl = detect_wdata_i;
		if (watchdog_reset_i) next_flags[`RSP_WATCHDOG_BIT] = 1'b1; // R3 R15
		if (undervolt_reset_i) next_flags[`RSP_UV_BIT] = 1'b1; // R4 R15
		if (cold_reset) next_flags = `RSP_FLAGS_RST; // R1
		if (cold_reset || watchdog_reset_i) begin
			next_det_ctrl = `RSP_ZERO_RST; // R5
			next_det_level = `RSP_ZERO_RST; // R5
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			flags <= `RSP_FLAGS_RST; // R1
			det_ctrl <= `RSP_ZERO_RST;
			det_level <= `RSP_ZERO_RST;
			internal_reset_o <= 1'b1; // R8
		end else begin
			flags <= next_flags;
			det_ctrl <= next_det_ctrl;
			det_level <= next_det_level;
			internal_reset_o <= next_internal_reset;
		end
	end

	assign reset_cause_flags_o = flags;
	assign undervolt_detect_control_o = det_ctrl;
	assign undervolt_level_select_o = det_level;

	// Peripheral registers forced to their reset values while reset is active
	always_comb begin
		next_serial_b_mode = serial_b_mode_o;
		next_serial_b_control = serial_b_control_o;
		next_serial_b_baud_divider = serial_b_baud_divider_o;
		next_serial_b_rx_buffer = serial_b_rx_buffer_o;
		next_serial_b_tx_buffer = serial_b_tx_buffer_o;
		next_biphase_transmit_buffer = biphase_transmit_buffer_o;
		next_biphase_bit_count = biphase_bit_count_o;
		next_biphase_control_first = biphase_control_first_o;
		next_biphase_control_third = biphase_control_third_o;
		next_biphase_state = biphase_state_o;
		next_display_mode_a = display_mode_a_o;
		next_display_mode_b = display_mode_b_o;
		next_display_clock_control = display_clock_control_o;
		next_key_return_mode = key_return_mode_o;
		next_rising_edge_enable = rising_edge_enable_o;
		next_falling_edge_enable = falling_edge_enable_o;
		if (any_reset) begin
			next_serial_b_mode = `RSP_SB_MODE_RST; // R10
			next_serial_b_control = `RSP_SB_CTRL_RST; // R10
			next_serial_b_baud_divider = `RSP_ONES_RST; // R10
			next_serial_b_rx_buffer = `RSP_ONES_RST; // R10
			next_serial_b_tx_buffer = `RSP_ONES_RST; // R10
			next_biphase_transmit_buffer = `RSP_ONES_RST; // R11
			next_biphase_bit_count = `RSP_BP_COUNT_RST; // R11
			next_biphase_control_first = `RSP_BP_CTRL1_RST; // R11
			next_biphase_control_third = `RSP_BP_CTRL3_RST; // R11
			next_biphase_state = `RSP_ZERO_RST; // R11
			next_display_mode_a = `RSP_ZERO_RST; // R13
			next_display_mode_b = `RSP_ZERO_RST; // R13
			next_display_clock_control = `RSP_ZERO_RST; // R13
			next_key_return_mode = `RSP_ZERO_RST; // R13
			next_rising_edge_enable = `RSP_ZERO_RST; // R13
			next_falling_edge_enable = `RSP_ZERO_RST; // R13
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			serial_b_mode_o <= `RSP_SB_MODE_RST; // R10 R7
			serial_b_control_o <= `RSP_SB_CTRL_RST; // R10
			serial_b_baud_divider_o <= `RSP_ONES_RST; // R10
			serial_b_rx_buffer_o <= `RSP_ONES_RST; // R10
			serial_b_tx_buffer_o <= `RSP_ONES_RST; // R10
			biphase_transmit_buffer_o <= `RSP_ONES_RST; // R11
			biphase_bit_count_o <= `RSP_BP_COUNT_RST; // R11
			biphase_control_first_o <= `RSP_BP_CTRL1_RST; // R11
			biphase_control_third_o <= `RSP_BP_CTRL3_RST; // R11
			biphase_state_o <= `RSP_ZERO_RST; // R11
			display_mode_a_o <= `RSP_ZERO_RST; // R13
			display_mode_b_o <= `RSP_ZERO_RST; // R13
			display_clock_control_o <= `RSP_ZERO_RST; // R13
			key_return_mode_o <= `RSP_ZERO_RST; // R13
			rising_edge_enable_o <= `RSP_ZERO_RST; // R13
			falling_edge_enable_o <= `RSP_ZERO_RST; // R13
		end else begin
			serial_b_mode_o <= next_serial_b_mode;
			serial_b_control_o <= next_serial_b_control;
			serial_b_baud_divider_o <= next_serial_b_baud_divider;
			serial_b_rx_buffer_o <= next_serial_b_rx_buffer;
			serial_b_tx_buffer_o <= next_serial_b_tx_buffer;
			biphase_transmit_buffer_o <= next_biphase_transmit_buffer;
			biphase_bit_count_o <= next_biphase_bit_count;
			biphase_control_first_o <= next_biphase_control_first;
			biphase_control_third_o <= next_biphase_control_third;
			biphase_state_o <= next_biphase_state;
			display_mode_a_o <= next_display_mode_a;
			display_mode_b_o <= next_display_mode_b;
			display_clock_control_o <= next_display_clock_control;
			key_return_mode_o <= next_key_return_mode;
			rising_edge_enable_o <= next_rising_edge_enable;
			falling_edge_enable_o <= next_falling_edge_enable;
		end
	end

	// Interrupt request, mask and priority bytes
	genvar gi;
	generate
		for (gi = 0; gi < IRQ_BYTES; gi++) begin : g_irq
			rsp_byte_t next_request;
			rsp_byte_t next_mask;
			rsp_byte_t next_priority;
			always_comb begin
				next_request = irq_request_o[8*gi +: 8];
				next_mask = irq_mask_o[8*gi +: 8];
				next_priority = irq_priority_o[8*gi +: 8];
				if (any_reset) begin
					next_request = `RSP_ZERO_RST; // R12
					next_mask = `RSP_ONES_RST; // R12
					next_priority = `RSP_ONES_RST; // R12
				end
			end
			always_ff @(posedge clock_i or negedge resetn_i) begin
				if (!resetn_i) begin
					irq_request_o[8*gi +: 8] <= `RSP_ZERO_RST; // R12
					irq_mask_o[8*gi +: 8] <= `RSP_ONES_RST; // R12
					irq_priority_o[8*gi +: 8] <= `RSP_ONES_RST; // R12
				end else begin
					irq_request_o[8*gi +: 8] <= next_request;
					irq_mask_o[8*gi +: 8] <= next_mask;
					irq_priority_o[8*gi +: 8] <= next_priority;
				end
			end
		end
	endgenerate

endmodule : rsp_reset_source
`default_nettype wire

// ===== dv/rsp_reset_source_props.sv
// Checker for the reset-source block ports
`timescale 1ns/10ps
`default_nettype none
module rsp_reset_source_props (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic reset_pin_n_i,
	input wire logic watchdog_reset_i,
	input wire logic undervolt_reset_i,
	input wire logic supply_above_low_i,
	input wire logic supply_above_high_i,
	input wire logic power_on_release_select_i,
	input wire logic flags_read_i,
	input wire logic internal_reset_o,
	input wire logic [7:0] reset_cause_flags_o,
	input wire logic [7:0] undervolt_detect_control_o,
	input wire logic [7:0] serial_b_mode_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!resetn_i);
	wire calm = reset_pin_n_i && supply_above_low_i && !internal_reset_o;
	wire quiet = reset_pin_n_i && !watchdog_reset_i && !undervolt_reset_i && supply_above_low_i;
	wire wdog = watchdog_reset_i;
	wire uv = undervolt_reset_i;
	a_pin_clear: assert property (!reset_pin_n_i |=> reset_cause_flags_o == 8'h00) else $error("flags kept");
	a_watchdog_set: assert property (wdog && !uv && calm |=>
		reset_cause_flags_o[1:0] == {$past(reset_cause_flags_o[1]), 1'b1}) else $error("watchdog flag");
	a_uv_set: assert property (uv && !wdog && calm |=>
		reset_cause_flags_o[1:0] == {1'b1, $past(reset_cause_flags_o[0])}) else $error("uv flag");
	a_read_clear: assert property (flags_read_i && !wdog && !uv && calm |=> reset_cause_flags_o == 8'h00) else $error("read");
	a_any_reset: assert property (!quiet |=> internal_reset_o) else $error("no reset");
	a_detect_kept: assert property (uv && !wdog && calm |=> $stable(undervolt_detect_control_o)) else $error("lost");
	a_detect_clear: assert property (wdog |=> undervolt_detect_control_o == 8'h00) else $error("kept");
	a_release: assert property ((quiet && (supply_above_high_i || !power_on_release_select_i))[*2]
		|=> !internal_reset_o) else $error("no release");
	a_high_wait: assert property (power_on_release_select_i && !supply_above_low_i ##1 (!supply_above_high_i)[*3]
		|-> internal_reset_o) else $error("early release");
	a_serial_mode: assert property (serial_b_mode_o == 8'h01) else $error("mode value");
endmodule : rsp_reset_source_props
`default_nettype wire

// ===== dv/rsp_src_model.sv
// Model of the reset pin, watchdog and supply comparators
`timescale 1ns/10ps
`default_nettype none
module rsp_src_model (
	input wire logic clock_i,
	output logic reset_pin_n_o,
	output logic watchdog_o,
	output logic undervolt_o,
	output logic above_low_o,
	output logic above_high_o
);
	initial {reset_pin_n_o, watchdog_o, undervolt_o, above_low_o, above_high_o} = 5'b10000;
	task automatic drive(input logic [4:0] v);
		@(negedge clock_i);
		{reset_pin_n_o, watchdog_o, undervolt_o, above_low_o, above_high_o} = v;
	endtask : drive
endmodule : rsp_src_model
`default_nettype wire

// ===== dv/testbench.sv
// Testbench for the reset-source block
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic clock_i, resetn_i, power_on_release_select_i, flags_read_i, detect_write_i;
	logic [7:0] detect_wdata_i;
	wire logic reset_pin_n_i, watchdog_reset_i, undervolt_reset_i, supply_above_low_i, supply_above_high_i;
	logic internal_reset_o;
	logic [7:0] reset_cause_flags_o, undervolt_detect_control_o, undervolt_level_select_o, serial_b_mode_o;
	logic [7:0] serial_b_control_o, serial_b_baud_divider_o, serial_b_rx_buffer_o, serial_b_tx_buffer_o;
	logic [7:0] biphase_transmit_buffer_o, biphase_bit_count_o, biphase_control_first_o, biphase_control_third_o;
	logic [7:0] biphase_state_o, display_mode_a_o, display_mode_b_o, display_clock_control_o;
	logic [7:0] key_return_mode_o, rising_edge_enable_o, falling_edge_enable_o;
	logic [31:0] irq_request_o, irq_mask_o, irq_priority_o;
	int failures = 0, n_checks = 0, cyc = 0;
	always #2 clock_i = ~clock_i;
	rsp_src_model i_src (.clock_i(clock_i), .reset_pin_n_o(reset_pin_n_i), .watchdog_o(watchdog_reset_i),
		.undervolt_o(undervolt_reset_i), .above_low_o(supply_above_low_i), .above_high_o(supply_above_high_i));
	rsp_reset_source #(.IRQ_BYTES(4)) i_dut (
		.clock_i(clock_i),
		.resetn_i(resetn_i),
		.reset_pin_n_i(reset_pin_n_i),
		.watchdog_reset_i(watchdog_reset_i),
		.undervolt_reset_i(undervolt_reset_i),
		.supply_above_low_i(supply_above_low_i),
		.supply_above_high_i(supply_above_high_i),
		.power_on_release_select_i(power_on_release_select_i),
		.flags_read_i(flags_read_i),
		.detect_write_i(detect_write_i),
		.detect_wdata_i(detect_wdata_i),
		.internal_reset_o(internal_reset_o),
		.reset_cause_flags_o(reset_cause_flags_o),
		.undervolt_detect_control_o(undervolt_detect_control_o),
		.undervolt_level_select_o(undervolt_level_select_o),
		.serial_b_mode_o(serial_b_mode_o),
		.serial_b_control_o(serial_b_control_o),
		.serial_b_baud_divider_o(serial_b_baud_divider_o),
		.serial_b_rx_buffer_o(serial_b_rx_buffer_o),
		.serial_b_tx_buffer_o(serial_b_tx_buffer_o),
		.biphase_transmit_buffer_o(biphase_transmit_buffer_o),
		.biphase_bit_count_o(biphase_bit_count_o),
		.biphase_control_first_o(biphase_control_first_o),
		.biphase_control_third_o(biphase_control_third_o),
		.biphase_state_o(biphase_state_o),
		.display_mode_a_o(display_mode_a_o),
		.display_mode_b_o(display_mode_b_o),
		.display_clock_control_o(display_clock_control_o),
		.key_return_mode_o(key_return_mode_o),
		.rising_edge_enable_o(rising_edge_enable_o),
		.falling_edge_enable_o(falling_edge_enable_o),
		.irq_request_o(irq_request_o),
		.irq_mask_o(irq_mask_o),
		.irq_priority_o(irq_priority_o)
	);
	task automatic give_verdict;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wrel;
		for (int k = 0; k < 40 && internal_reset_o !== 1'b0; k++) @(negedge clock_i);
	endtask : wrel
	task automatic src(input logic [4:0] v);
		i_src.drive(v);
		i_src.drive(5'b10011);
		wrel();
	endtask : src
	task automatic t_power_up;
		chk(internal_reset_o, 1);
		chk({serial_b_mode_o, serial_b_control_o, serial_b_baud_divider_o, serial_b_rx_buffer_o, serial_b_tx_buffer_o,
			biphase_transmit_buffer_o, biphase_bit_count_o, biphase_control_first_o}, 64'h0116_FFFF_FFFF_0710);
		chk({biphase_control_third_o, biphase_state_o, display_mode_a_o, display_mode_b_o, display_clock_control_o,
			key_return_mode_o, rising_edge_enable_o, falling_edge_enable_o}, 64'h1F00_0000_0000_0000);
		chk({irq_request_o, irq_mask_o}, 64'h0000_0000_FFFF_FFFF);
		chk({irq_priority_o, reset_cause_flags_o, undervolt_detect_control_o, undervolt_level_select_o},
			64'h00FF_FFFF_FF00_0000);
		i_src.drive(5'b10010);
		wrel();
		chk(internal_reset_o, 0);
		$display("test power_up done");
	endtask : t_power_up
	task automatic t_sources;
		src(5'b11011);
		chk(reset_cause_flags_o, 8'h01);
		@(negedge clock_i);
		detect_write_i = 1;
		detect_wdata_i = 8'h5A;
		@(negedge clock_i);
		detect_write_i = 0;
		src(5'b10111);
		chk({reset_cause_flags_o, undervolt_detect_control_o}, 16'h035A);
		src(5'b11011);
		chk({reset_cause_flags_o, undervolt_detect_control_o}, 16'h0300);
		@(negedge clock_i);
		flags_read_i = 1;
		@(negedge clock_i);
		flags_read_i = 0;
		chk(reset_cause_flags_o, 8'h00);
		$display("test sources done");
	endtask : t_sources
	task automatic t_pin_power;
		src(5'b11011);
		src(5'b00011);
		chk(reset_cause_flags_o, 8'h00);
		src(5'b11011);
		power_on_release_select_i = 1;
		i_src.drive(5'b10000);
		i_src.drive(5'b10010);
		repeat (6) @(negedge clock_i);
		chk({internal_reset_o, reset_cause_flags_o}, 9'h100);
		i_src.drive(5'b10011);
		wrel();
		chk(internal_reset_o, 0);
		$display("test pin_power done");
	endtask : t_pin_power
	always @(posedge clock_i) begin
		cyc++;
		if (cyc == 2000) begin
			failures++;
			give_verdict();
		end
	end
	initial begin
		clock_i = 1'b0;
		resetn_i = 1'b0;
		power_on_release_select_i = 1'b0;
		flags_read_i = 1'b0;
		detect_write_i = 1'b0;
		detect_wdata_i = 8'h00;
		repeat (12) @(negedge clock_i);
		resetn_i = 1;
		t_power_up();
		t_sources();
		t_pin_power();
		give_verdict();
	end
endmodule : testbench
bind rsp_reset_source rsp_reset_source_props i_props (
	.clock_i(clock_i),
	.resetn_i(resetn_i),
	.reset_pin_n_i(reset_pin_n_i),
	.watchdog_reset_i(watchdog_reset_i),
	.undervolt_reset_i(undervolt_reset_i),
	.supply_above_low_i(supply_above_low_i),
	.supply_above_high_i(supply_above_high_i),
	.power_on_release_select_i(power_on_release_select_i),
	.flags_read_i(flags_read_i),
	.internal_reset_o(internal_reset_o),
	.reset_cause_flags_o(reset_cause_flags_o),
	.undervolt_detect_control_o(undervolt_detect_control_o),
	.serial_b_mode_o(serial_b_mode_o)
);
`default_nettype wire
